// ===== rtl/extreme_value_search_control.sv
// extreme value search control: button handling, two-pass max/min search over sample memory,
// display code conversion and raw binary output; registers over apb.
// assumes sample memory answers combinationally to mem_addr, and buttons are asynchronous pins.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
module extreme_value_search_control
  import xsearch_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // front panel pins
  input  wire logic              max_button,
  input  wire logic              min_button,
  input  wire logic              busy_inhibit,
  // sample memory
  output logic      [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] mem_data,
  // displays and computer outputs
  output logic      [15:0]       temp_display,
  output logic      [15:0]       addr_display,
  output raw_out_t               raw_out,
  output logic                   timing_cycle_request
);

  // pin synchronisers
  logic [2:0] sync1_q, sync2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {busy_inhibit, min_button, max_button};
      sync2_q <= sync1_q;
    end
  end

  // debounce: one counter per button, press fires once after stable interval
  localparam int CNT_W = $clog2(DEBOUNCE_CYCLES + 1);
  logic [CNT_W-1:0] db_cnt_q [2];
  logic [1:0]       db_lvl_q;
  logic [1:0]       press_pin;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_cnt_q[0] <= '0;
      db_cnt_q[1] <= '0;
      db_lvl_q    <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sync2_q[i] == db_lvl_q[i]) begin
          db_cnt_q[i] <= '0;
        end else if (db_cnt_q[i] == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
          db_cnt_q[i] <= '0;
          db_lvl_q[i] <= sync2_q[i];
        end else begin
          db_cnt_q[i] <= db_cnt_q[i] + 1'b1;
        end
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      press_pin[i] = (db_cnt_q[i] == CNT_W'(DEBOUNCE_CYCLES - 1)) && sync2_q[i] && !db_lvl_q[i];
    end
  end

  // apb side presses
  logic       wr_ctrl;
  logic       lin_en_q;
  logic       press_max, press_min, press_other, press_any;
  assign wr_ctrl     = psel && penable && pwrite && (paddr == CTRL_OFF);
  // inhibit covers transfer, plot and error states reported by the host logic
  assign press_max   = (press_pin[0] || (wr_ctrl && pwdata[CTRL_MAX_BIT])) && !sync2_q[2];
  assign press_min   = (press_pin[1] || (wr_ctrl && pwdata[CTRL_MIN_BIT])) && !sync2_q[2] && !press_max;
  assign press_other = wr_ctrl && pwdata[CTRL_OTHER_BIT];
  assign press_any   = press_max || press_min;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lin_en_q <= LIN_EN_RST;
    else if (wr_ctrl) lin_en_q <= pwdata[CTRL_LIN_BIT];
  end

  // mode flags
  logic extreme_polarity_flag_q, mode_history_flag_q, first_entry_flag_q, new_search;
  logic continue_search_flag_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extreme_polarity_flag_q <= 1'b1;
      mode_history_flag_q     <= 1'b1;
      first_entry_flag_q      <= 1'b0;
    end else begin
      if (press_max) extreme_polarity_flag_q <= 1'b1;
      else if (press_min) extreme_polarity_flag_q <= 1'b0;
      if (press_any) mode_history_flag_q <= 1'b0;
      else if (press_other) mode_history_flag_q <= 1'b1;
      if (press_any) first_entry_flag_q <= mode_history_flag_q;
    end
  end
  // entry or polarity flip both start a fresh search
  assign new_search = press_any && (mode_history_flag_q
                      || (press_max != extreme_polarity_flag_q));

  // search sequencer
  search_state_t     state_q;
  logic              first_pass_flag;
  logic [ADDR_W-1:0] addr_q, best_addr_q;
  logic [DATA_W-1:0] best_q;
  logic              match_not_found_signal, better, at_end, step;
  assign first_pass_flag        = (state_q == LOAD) || (state_q == PASS1);
  assign match_not_found_signal = (state_q == PASS2) && (mem_data != best_q);
  assign better  = extreme_polarity_flag_q ? (mem_data >= best_q) : (mem_data <= best_q);
  assign at_end  = (addr_q == {ADDR_W{1'b1}});
  // request_or_gate: first pass, continue, or still hunting in pass two
  assign timing_cycle_request = first_pass_flag || continue_search_flag_q
                                || match_not_found_signal;
  assign step = timing_cycle_request;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= IDLE;
      addr_q      <= '0;
      best_q      <= '0;
      best_addr_q <= '0;
    end else if (new_search) begin
      state_q <= LOAD;
      addr_q  <= '0;
    end else begin
      unique case (state_q)
        IDLE: ;
        LOAD: begin
          best_q      <= mem_data;
          best_addr_q <= '0;
          addr_q      <= ADDR_W'(1);
          state_q     <= PASS1;
        end
        PASS1: begin
          if (better) begin
            best_q      <= mem_data;
            best_addr_q <= addr_q;
          end
          addr_q <= addr_q + 1'b1;
          if (at_end) state_q <= PASS2;
        end
        PASS2: begin
          // stop when the addressed sample matches; otherwise keep walking
          if (step && !continue_search_flag_q) begin
            if (match_not_found_signal) addr_q <= addr_q + 1'b1;
          end else if (continue_search_flag_q) begin
            addr_q <= addr_q + 1'b1;
          end
        end
      endcase
    end
  end

  // continue: same extreme pressed again; first timing pulse clears it, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) continue_search_flag_q <= 1'b0;
    else if (press_any && !new_search && state_q == PASS2) continue_search_flag_q <= 1'b1;
    else if (continue_search_flag_q) continue_search_flag_q <= 1'b0;
  end

  assign mem_addr = addr_q;

  // display conversion
  function automatic logic [15:0] to_digits(input int val, input logic signed_en);
    int a;
    logic [15:0] d;
    logic lead;
    int p;
    a = (val < 0) ? -val : val;
    d = '0;
    for (int k = 0; k < DIGITS; k++) begin
      d[k*4 +: 4] = 4'(a % 10);
      a = a / 10;
    end
    lead = 1'b1;
    p = -1;
    for (int k = DIGITS - 1; k > 0; k--) begin
      if (lead && d[k*4 +: 4] == 4'h0) begin
        d[k*4 +: 4] = BLANK_DIGIT;
        p = k;
      end else begin
        lead = 1'b0;
      end
    end
    if (signed_en && val < 0 && p >= 0) d[p*4 +: 4] = MINUS_DIGIT;
    return d;
  endfunction

  function automatic int temp_tenths(input logic [DATA_W-1:0] code);
    return (int'(code) * SCALE_NUM) / SCALE_DEN + TEMP_OFFSET10;
  endfunction

  // linearizer: upper byte of the code squared; identity unless enabled
  function automatic logic [DATA_W-1:0] linearize(input logic [DATA_W-1:0] code);
    logic [15:0] sq;
    sq = 16'(code) * 16'(code);
    return sq[15:8];
  endfunction

  logic [DATA_W-1:0] shown_data;
  assign shown_data = (state_q == PASS1 || state_q == LOAD) ? best_q : mem_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_display <= '0;
      addr_display <= '0;
      raw_out      <= '0;
    end else begin
      temp_display <= (shown_data == SYS_CODE) ? SYS_DISPLAY
                      : to_digits(temp_tenths(shown_data), 1'b1);
      addr_display <= to_digits(int'(addr_q), 1'b0);
      raw_out.addr <= addr_q;
      raw_out.data <= lin_en_q ? linearize(shown_data) : shown_data;
      raw_out.valid <= (state_q == PASS2) && !timing_cycle_request;
    end
  end

  // apb read side, zero wait states
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr inside {CTRL_OFF, STATUS_OFF, EXTREME_OFF,
                                                      DISPLAY_OFF, RAW_OFF});
  always_comb begin
    prdata = '0;
    if (psel && !pwrite) begin
      unique case (paddr)
        CTRL_OFF:    prdata = {28'h0, lin_en_q, 3'h0};
        STATUS_OFF:  prdata = {24'h0, state_q, continue_search_flag_q, first_entry_flag_q,
                               mode_history_flag_q, extreme_polarity_flag_q, first_pass_flag,
                               timing_cycle_request};
        EXTREME_OFF: prdata = {8'h0, 5'h0, best_addr_q, best_q};
        DISPLAY_OFF: prdata = {addr_display, temp_display};
        RAW_OFF:     prdata = {12'h0, raw_out};
        default:     prdata = '0;
      endcase
    end
  end

  // checks
  polarity_max_a: assert property (@(posedge pclk) disable iff (!presetn)
    press_max |=> extreme_polarity_flag_q)
    else $error("max press did not set polarity");
  polarity_min_a: assert property (@(posedge pclk) disable iff (!presetn)
    press_min |=> !extreme_polarity_flag_q)
    else $error("min press did not clear polarity");
  history_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    press_any |=> !mode_history_flag_q)
    else $error("history not low after search press");
  entry_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    press_any |=> first_entry_flag_q == $past(mode_history_flag_q))
    else $error("entry flag wrong");
  new_search_a: assert property (@(posedge pclk) disable iff (!presetn)
    new_search |=> state_q == LOAD && addr_q == '0)
    else $error("new search did not restart");
  request_or_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_pass_flag |-> timing_cycle_request)
    else $error("first pass without timing");
  match_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == PASS2 && mem_data == best_q && !continue_search_flag_q && !press_any)
      |=> $stable(addr_q))
    else $error("second pass did not halt on match");
  continue_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    continue_search_flag_q && !press_any |=> !continue_search_flag_q)
    else $error("continue not cleared");
  sys_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    shown_data == SYS_CODE |=> temp_display == SYS_DISPLAY)
    else $error("system code not dashes");
  raw_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> raw_out.addr == $past(addr_q))
    else $error("raw address mismatch");
  pass_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == PASS1 && at_end && !new_search) |=> state_q == PASS2)
    else $error("first pass did not end");
  inhibit_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    sync2_q[2] && !press_other |=> $stable(extreme_polarity_flag_q) && $stable(mode_history_flag_q))
    else $error("search press taken while inhibited");
  other_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    press_other && !press_any |=> mode_history_flag_q)
    else $error("history not high after other press");
  first_pass_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    new_search |=> first_pass_flag)
    else $error("new search did not set first pass");
  first_pass_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_pass_flag && !new_search && !(state_q == PASS1 && at_end) |=> first_pass_flag)
    else $error("first pass cut short");
  scan_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == PASS1 && !new_search |=> addr_q == $past(addr_q) + 1'b1)
    else $error("first pass skipped an address");
  hunt_request_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == PASS2 && mem_data != best_q |-> timing_cycle_request)
    else $error("no timing while hunting");
  halt_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == PASS2 && mem_data == best_q && !continue_search_flag_q |-> !timing_cycle_request)
    else $error("timing requested at match");
  continue_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    press_any && !new_search && state_q == PASS2 |=> continue_search_flag_q)
    else $error("repeat press did not continue");
  continue_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    continue_search_flag_q && state_q == PASS2 && !new_search |=> addr_q == $past(addr_q) + 1'b1)
    else $error("continue did not leave the match");
  scan_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == PASS1 && better && !new_search |=> best_q == $past(mem_data) && best_addr_q == $past(addr_q))
    else $error("better sample not kept");
  scan_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == PASS1 && !better && !new_search |=> $stable(best_q) && $stable(best_addr_q))
    else $error("worse sample replaced extreme");
  load_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == LOAD && !new_search |=> best_addr_q == '0 && best_q == $past(mem_data) && addr_q == ADDR_W'(1))
    else $error("sample zero not loaded");
  raw_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == PASS2 && !timing_cycle_request |=> raw_out.valid)
    else $error("valid missing while halted");
  raw_invalid_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q != PASS2 |=> !raw_out.valid)
    else $error("valid outside second pass");
  lin_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !lin_en_q |=> raw_out.data == $past(shown_data))
    else $error("raw data not passed straight");
  addr_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    addr_q == '0 |=> addr_display == {BLANK_DIGIT, BLANK_DIGIT, BLANK_DIGIT, 4'h0})
    else $error("address zero not blanked");

endmodule

// ===== rtl/xsearch_pkg.sv
// shared constants and carrier types for the extreme value search control
// assumes an 11-bit sample address space and 8-bit samples
package xsearch_pkg;
  localparam int          ADDR_W        = 11;
  localparam int          DATA_W        = 8;
  localparam int          DIGITS        = 4;
  // apb register map (byte addresses)
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  STATUS_OFF    = 8'h04;
  localparam logic [7:0]  EXTREME_OFF   = 8'h08;
  localparam logic [7:0]  DISPLAY_OFF   = 8'h0C;
  localparam logic [7:0]  RAW_OFF       = 8'h10;
  // ctrl bit positions (bits 0-2: write 1 = press, self clearing; bit 3 linearizer enable, held)
  localparam int          CTRL_MAX_BIT   = 0;
  localparam int          CTRL_MIN_BIT   = 1;
  localparam int          CTRL_OTHER_BIT = 2;
  localparam int          CTRL_LIN_BIT   = 3;
  localparam logic        LIN_EN_RST     = 1'b0;
  // debounce: 5 ms hold-off, button must be stable this long
  localparam int          DEBOUNCE_US    = 5000;
  localparam int          CLK_MHZ        = 250;
  localparam int          DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
  localparam logic [7:0]  SYS_CODE       = 8'hFF;
  localparam logic [15:0] SYS_DISPLAY    = 16'hDDDD;
  localparam logic [3:0]  BLANK_DIGIT    = 4'hF;
  localparam logic [3:0]  MINUS_DIGIT    = 4'hB;
  // raw code to tenths of a degree: deg10 = code*SCALE_NUM/SCALE_DEN + OFFSET
  localparam int          TEMP_OFFSET10  = -100;
  localparam int          SCALE_NUM      = 600;
  localparam int          SCALE_DEN      = 254;

  typedef enum logic [1:0] {
    IDLE  = 2'b00,
    LOAD  = 2'b01,
    PASS1 = 2'b11,
    PASS2 = 2'b10
  } search_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              valid;
  } raw_out_t;
endpackage

// ===== sim/sample_rom_model.sv
// sample memory seen by the search control: combinational read of 2048 bytes
// assumes the bench picks whether the system code sits at one location
`timescale 1ns/1ns
module sample_rom_model
  import xsearch_pkg::*;
(
  // memory port
  input  wire logic [ADDR_W-1:0] mem_addr,
  output logic      [DATA_W-1:0] mem_data,
  // bench control
  input  wire logic              put_sys_code
);
  // two maxima and two minima so repeat presses have somewhere to step to
  always_comb begin
    case (mem_addr)
      11'h064, 11'h384: mem_data = 8'hF0;
      11'h032, 11'h5DC: mem_data = 8'h05;
      11'h4D2:          mem_data = put_sys_code ? SYS_CODE : 8'h44;
      default:          mem_data = {3'b010, mem_addr[4:0]};
    endcase
  end
endmodule

// ===== sim/extreme_value_search_control_tb_top.sv
// self-checking bench for the extreme value search control
// assumes zero-wait apb slave and a short debounce count for simulation
`timescale 1ns/1ns
module extreme_value_search_control_tb_top;
  import xsearch_pkg::*;
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [10:0] addr;
    logic [7:0]  val;
    logic        pol;
    logic        first;
    logic [15:0] adisp;
  } row_t;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              max_button, min_button, busy_inhibit, put_sys_code, er;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_data;
  logic [15:0]       temp_display, addr_display;
  raw_out_t          raw_out;
  logic              timing_cycle_request;
  int                failures, n_tests, cyc;
  row_t              rows [7];
  extreme_value_search_control #(.DEBOUNCE_CYCLES(4)) extreme_value_search_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .max_button(max_button), .min_button(min_button), .busy_inhibit(busy_inhibit),
    .mem_addr(mem_addr), .mem_data(mem_data), .temp_display(temp_display),
    .addr_display(addr_display), .raw_out(raw_out), .timing_cycle_request(timing_cycle_request));
  sample_rom_model sample_rom_model_inst (.mem_addr(mem_addr), .mem_data(mem_data), .put_sys_code(put_sys_code));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches=%0d comparisons=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // a continue press leaves pass two halted, so give it time to move first
  task automatic wait_halt();
    repeat (6) @(posedge pclk);
    apb(1'b0, STATUS_OFF, 32'h0);
    while (!(rd[7:6] === 2'b10 && rd[0] === 1'b0)) apb(1'b0, STATUS_OFF, 32'h0);
    repeat (3) @(posedge pclk);
  endtask
  task automatic expect_halt(input row_t r);
    check(mem_addr, r.addr);
    check(timing_cycle_request, 1'b0);
    apb(1'b0, EXTREME_OFF, 32'h0);
    check(rd[7:0], r.val);
    check(rd[18:8], r.pol ? 11'd900 : 11'd1500);
    apb(1'b0, STATUS_OFF, 32'h0);
    check(rd[2], r.pol);
    check(rd[3], 1'b0);
    check(rd[4], r.first);
    check(addr_display, r.adisp);
    check(temp_display, r.pol ? 16'hF466 : 16'hFB89);
    check(raw_out, {r.addr, r.val, 1'b1});
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    failures = 0; n_tests = 0; cyc = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    max_button = 1'b0; min_button = 1'b0; busy_inhibit = 1'b0; put_sys_code = 1'b0;
    //        ctrl   addr    val    pol   first adisp
    rows[0] = '{4'h1, 11'd100, 8'hF0, 1'b1, 1'b1, 16'hF100};
    rows[1] = '{4'h1, 11'd900, 8'hF0, 1'b1, 1'b0, 16'hF900};
    rows[2] = '{4'h1, 11'd100, 8'hF0, 1'b1, 1'b0, 16'hF100};
    rows[3] = '{4'h2, 11'd50, 8'h05, 1'b0, 1'b0, 16'hFF50};
    rows[4] = '{4'h2, 11'd1500, 8'h05, 1'b0, 1'b0, 16'h1500};
    rows[5] = '{4'h4, 11'd0, 8'h00, 1'b0, 1'b0, 16'h0000};
    rows[6] = '{4'h2, 11'd50, 8'h05, 1'b0, 1'b1, 16'hFF50};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, STATUS_OFF, 32'h0);
    check(rd[3:0], 4'hC);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, CTRL_OFF, {28'h0, rows[i].ctrl});
      if (rows[i].ctrl == 4'h4) begin
        apb(1'b0, STATUS_OFF, 32'h0);
        check(rd[3], 1'b1);
      end else begin
        wait_halt();
        expect_halt(rows[i]);
      end
    end
    // pin presses while inhibited must be dropped
    busy_inhibit <= 1'b1;
    max_button <= 1'b1;
    repeat (12) @(posedge pclk);
    max_button <= 1'b0;
    repeat (12) @(posedge pclk);
    busy_inhibit <= 1'b0;
    check(mem_addr, 11'd50);
    apb(1'b0, STATUS_OFF, 32'h0);
    check(rd[7:6], 2'b10);
    check(rd[2], 1'b0);
    // debounced pin press flips to a new maximum search
    max_button <= 1'b1;
    repeat (12) @(posedge pclk);
    max_button <= 1'b0;
    wait_halt();
    expect_halt(rows[2]);
    // linearizer on: halted maximum F0 squared, upper byte
    apb(1'b1, CTRL_OFF, 32'h8);
    apb(1'b0, CTRL_OFF, 32'h0);
    check(rd[3], 1'b1);
    check(raw_out.data, 8'hE1);
    // system code outranks every sample and shows as dashes
    put_sys_code <= 1'b1;
    apb(1'b1, CTRL_OFF, 32'h4);
    apb(1'b1, CTRL_OFF, 32'h1);
    wait_halt();
    check(mem_addr, 11'd1234);
    check(temp_display, SYS_DISPLAY);
    check(addr_display, 16'h1234);
    // unmapped place is refused
    apb(1'b0, 8'h20, 32'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
    give_verdict();
  end
endmodule
